// >>> rtl/kcc_device.sv
// device end: frame receiver, task key decoder and config one register
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
// How it works
// RULE1: key register at 0x08, low bits read zero
// RULE2: unknown task codes do nothing at all; here they still drop an armed two-code sequence
// RULE3: readback bit21 inverted alarm, 20:16 address
// RULE4: 0x4765 locks config, starts reference CRC
// RULE5: unlock needs 0x896D then 0x57AB
// RULE6: 0x15FA arms software reset sequence
// RULE7: 0x1ADC starts one ADC conversion
// RULE8: 0x0D06 arms watchdog reset sequence
// RULE9: 0x5CEA forces background CRC recalculation
// RULE10: 0xFCBA refreshes calibration once per reset
// RULE11: config at 0x09, bits 15:14 read zero
// RULE12: bits 13:12 pick temperature trip point
// RULE13: select 00 idles pin, 01 clocks it
// RULE14: host never writes select codes 10, 11
// RULE15: bits 9:7 pick output rate, reset 100
// RULE16: second code must be next key write
module kcc_device #(
  parameter logic [15:0] SWRST_KEY2 = 16'h0001,
  parameter logic [15:0] WDOG_KEY2 = 16'h0002
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic alarmPin,
  kcc_link_if.device link,
  output logic cfgLocked,
  output logic lockCrcStart,
  output logic swResetStart,
  output logic adcStart,
  output logic wdogReset,
  output logic crcRecalc,
  output logic calRefresh,
  output logic [1:0] tempTripSel,
  output logic [7:0] tempTripDegC,
  output logic [1:0] clkOutSel,
  output logic [2:0] clkOutRate,
  output logic clockOutputPin
);
  import kcc_pkg::*;

  logic [4:0] bitCnt_r;
  logic [23:0] rxSh_r;
  logic rxDone_r;
  logic miso_r;
  logic [23:0] rdWord_r;
  logic doneSync1_r;
  logic doneSync2_r;
  logic doneSeen_r;
  logic alarmSync1_r;
  logic alarmSync2_r;
  logic frameEv;
  logic wrEv;
  logic rdEv;
  logic keyWr;
  logic cfgWr;
  logic [4:0] addr;
  logic [15:0] data;
  kcc_seq_t seq_r;
  logic calDone_r;
  logic [1:0] trip_r;
  logic [1:0] ckSel_r;
  logic [2:0] rate_r;
  logic [6:0] misc_r;
  logic [7:0] divCnt_r;
  logic clkPin_r;

  // link side, clocked by the link; chip select low is the frame
  always_ff @(posedge link.sclk or posedge link.csN) begin
    if (link.csN) begin
      bitCnt_r <= 5'h00;
    end else if (bitCnt_r != KCC_BITS_DONE) begin
      bitCnt_r <= bitCnt_r + 5'h01;
    end
  end

  // held until the next frame's first link clock rise, so the mclk side reads it stable
  always_ff @(posedge link.sclk) begin
    if (bitCnt_r != KCC_BITS_DONE) begin
      rxSh_r <= {rxSh_r[22:0], link.mosi};
    end
  end

  // level lasts until chip select rises; host keeps a tail for the sync
  always_ff @(posedge link.sclk or posedge link.csN) begin
    if (link.csN) begin
      rxDone_r <= 1'b0;
    end else if (bitCnt_r == KCC_LAST_BIT) begin
      rxDone_r <= 1'b1;
    end
  end

  // readback word is static during a frame, changed only after the last edge
  always_ff @(posedge link.sclk or posedge link.csN) begin
    if (link.csN) begin
      miso_r <= 1'b0;
    end else if (bitCnt_r != KCC_BITS_DONE) begin
      miso_r <= rdWord_r[KCC_LAST_BIT - bitCnt_r];
    end
  end

  assign link.miso = miso_r;

  // crossing into the oscillator domain
  always_ff @(posedge mclk) begin
    if (rst) begin
      doneSync1_r <= 1'b0;
      doneSync2_r <= 1'b0;
      doneSeen_r <= 1'b0;
      alarmSync1_r <= 1'b0;
      alarmSync2_r <= 1'b0;
    end else begin
      doneSync1_r <= rxDone_r;
      doneSync2_r <= doneSync1_r;
      doneSeen_r <= doneSync2_r;
      alarmSync1_r <= alarmPin;
      alarmSync2_r <= alarmSync1_r;
    end
  end

  assign frameEv = doneSync2_r & ~doneSeen_r;
  assign addr = rxSh_r[KCC_ADDR_HI:KCC_ADDR_LO];
  assign data = rxSh_r[15:0];
  assign wrEv = frameEv & ~rxSh_r[KCC_RD_BIT];
  assign rdEv = frameEv & rxSh_r[KCC_RD_BIT];
  assign keyWr = wrEv && (addr == KCC_ADDR_KEY);
  assign cfgWr = wrEv && (addr == KCC_ADDR_CFG1) && !cfgLocked;

  // readback for the next frame
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdWord_r <= 24'h000000;
    end else if (rdEv) begin
      rdWord_r <= 24'h000000; // RULE1
      rdWord_r[KCC_ALARM_BIT] <= ~alarmSync2_r; // RULE3
      rdWord_r[KCC_ADDR_HI:KCC_ADDR_LO] <= addr; // RULE3
      if (addr == KCC_ADDR_CFG1) begin
        rdWord_r[15:0] <= {2'b00, trip_r, ckSel_r, rate_r, misc_r}; // RULE11
      end
    end
  end

  // two-code sequences: any other key write drops the armed one
  always_ff @(posedge mclk) begin
    if (rst) begin
      seq_r <= SEQ_NONE;
    end else if (keyWr) begin
      case (data)
        KCC_KEY_UNLOCK1: seq_r <= SEQ_UNLOCK; // RULE5
        KCC_KEY_SWRST1: seq_r <= SEQ_SWRST; // RULE6
        KCC_KEY_WDOG1: seq_r <= SEQ_WDOG; // RULE8
        default: seq_r <= SEQ_NONE; // RULE2 RULE16
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cfgLocked <= 1'b0;
    end else if (keyWr && data == KCC_KEY_LOCK) begin
      cfgLocked <= 1'b1; // RULE4
    end else if (keyWr && data == KCC_KEY_UNLOCK2 && seq_r == SEQ_UNLOCK) begin
      cfgLocked <= 1'b0; // RULE5
    end
  end

  // one-cycle task strobes; unlisted codes fall through untouched
  always_ff @(posedge mclk) begin
    if (rst) begin
      lockCrcStart <= 1'b0;
      adcStart <= 1'b0;
      crcRecalc <= 1'b0;
      swResetStart <= 1'b0;
      wdogReset <= 1'b0;
    end else begin
      lockCrcStart <= keyWr && data == KCC_KEY_LOCK; // RULE4
      adcStart <= keyWr && data == KCC_KEY_ADC; // RULE7
      crcRecalc <= keyWr && data == KCC_KEY_CRC; // RULE9
      swResetStart <= keyWr && seq_r == SEQ_SWRST && data == SWRST_KEY2; // RULE16
      wdogReset <= keyWr && seq_r == SEQ_WDOG && data == WDOG_KEY2; // RULE16
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      calDone_r <= 1'b0;
      calRefresh <= 1'b0;
    end else begin
      calRefresh <= keyWr && data == KCC_KEY_CAL && !calDone_r; // RULE10
      if (keyWr && data == KCC_KEY_CAL) begin
        calDone_r <= 1'b1; // RULE10
      end
    end
  end

  // config one; writes ignored while locked
  always_ff @(posedge mclk) begin
    if (rst) begin
      trip_r <= KCC_TRIP_RESET;
      ckSel_r <= KCC_CKSEL_OFF;
      rate_r <= KCC_RATE_RESET; // RULE15
      misc_r <= KCC_MISC_RESET;
    end else if (cfgWr) begin
      trip_r <= data[KCC_TRIP_HI:KCC_TRIP_LO]; // RULE12
      ckSel_r <= data[KCC_CKSEL_HI:KCC_CKSEL_LO]; // RULE13
      rate_r <= data[KCC_RATE_HI:KCC_RATE_LO]; // RULE15
      misc_r <= data[KCC_MISC_HI:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      tempTripSel <= KCC_TRIP_RESET;
      tempTripDegC <= kccTripDegC(KCC_TRIP_RESET);
      clkOutSel <= KCC_CKSEL_OFF;
      clkOutRate <= KCC_RATE_RESET;
    end else begin
      tempTripSel <= trip_r;
      tempTripDegC <= kccTripDegC(trip_r); // RULE12
      clkOutSel <= ckSel_r;
      clkOutRate <= rate_r;
    end
  end

  // reserved select codes behave as off, a safe idle pin
  always_ff @(posedge mclk) begin
    if (rst) begin
      divCnt_r <= 8'h00;
      clkPin_r <= 1'b0;
    end else if (ckSel_r != KCC_CKSEL_ON) begin
      divCnt_r <= 8'h00; // RULE13
      clkPin_r <= 1'b0; // RULE13
    end else if (divCnt_r >= kccHalfCycles(rate_r) - 8'h01) begin
      divCnt_r <= 8'h00;
      clkPin_r <= ~clkPin_r; // RULE15
    end else begin
      divCnt_r <= divCnt_r + 8'h01;
    end
  end

  assign clockOutputPin = clkPin_r;
endmodule : kcc_device

// >>> include/kcc_pkg.sv
// shared constants, codes and lookups for the key command and config block
package kcc_pkg;
  // register map and reset words
  localparam logic [4:0] KCC_ADDR_KEY = 5'h08;
  localparam logic [4:0] KCC_ADDR_CFG1 = 5'h09;
  localparam logic [23:0] KCC_KEY_RESET = 24'h080000;
  localparam logic [23:0] KCC_CFG1_RESET = 24'h090204;
  // frame layout
  localparam int KCC_FRAME_BITS = 24;
  localparam logic [4:0] KCC_LAST_BIT = 5'h17;
  localparam logic [4:0] KCC_BITS_DONE = 5'h18;
  localparam int KCC_RD_BIT = 23;
  localparam int KCC_ALARM_BIT = 21;
  localparam int KCC_ADDR_HI = 20;
  localparam int KCC_ADDR_LO = 16;
  // config one field positions
  localparam int KCC_TRIP_HI = 13;
  localparam int KCC_TRIP_LO = 12;
  localparam int KCC_CKSEL_HI = 11;
  localparam int KCC_CKSEL_LO = 10;
  localparam int KCC_RATE_HI = 9;
  localparam int KCC_RATE_LO = 7;
  localparam int KCC_MISC_HI = 6;
  localparam logic [1:0] KCC_TRIP_RESET = 2'h0;
  localparam logic [1:0] KCC_CKSEL_OFF = 2'h0;
  localparam logic [1:0] KCC_CKSEL_ON = 2'h1;
  localparam logic [2:0] KCC_RATE_RESET = 3'h4;
  localparam logic [6:0] KCC_MISC_RESET = 7'h04;
  // task codes
  localparam logic [15:0] KCC_KEY_LOCK = 16'h4765;
  localparam logic [15:0] KCC_KEY_UNLOCK1 = 16'h896d;
  localparam logic [15:0] KCC_KEY_UNLOCK2 = 16'h57ab;
  localparam logic [15:0] KCC_KEY_SWRST1 = 16'h15fa;
  localparam logic [15:0] KCC_KEY_ADC = 16'h1adc;
  localparam logic [15:0] KCC_KEY_WDOG1 = 16'h0d06;
  localparam logic [15:0] KCC_KEY_CRC = 16'h5cea;
  localparam logic [15:0] KCC_KEY_CAL = 16'hfcba;
  // timing
  localparam int KCC_MCLK_KHZ = 100000;
  localparam int KCC_SCLK_HALF = 3;
  localparam int KCC_CS_TAIL = 8;
  localparam int KCC_FRAME_GAP = 16;
  // host command port offsets
  localparam logic [1:0] KCC_HREG_TX = 2'h0;
  localparam logic [1:0] KCC_HREG_STATUS = 2'h1;
  localparam logic [1:0] KCC_HREG_RX = 2'h2;

  typedef enum logic [1:0] {SEQ_NONE, SEQ_UNLOCK, SEQ_SWRST, SEQ_WDOG} kcc_seq_t;
  typedef enum logic [1:0] {HST_IDLE, HST_SHIFT, HST_TAIL, HST_GAP} kcc_hstate_t;

  function automatic int kccRateKhz(input logic [2:0] code);
    case (code)
      3'h0: kccRateKhz = 416;
      3'h1: kccRateKhz = 435;
      3'h2: kccRateKhz = 454;
      3'h3: kccRateKhz = 476;
      3'h4: kccRateKhz = 500;
      3'h5: kccRateKhz = 526;
      3'h6: kccRateKhz = 555;
      default: kccRateKhz = 588;
    endcase
  endfunction : kccRateKhz

  // half period of the clock output in mclk cycles
  function automatic logic [7:0] kccHalfCycles(input logic [2:0] code);
    kccHalfCycles = 8'(KCC_MCLK_KHZ / (2 * kccRateKhz(code)));
  endfunction : kccHalfCycles

  function automatic logic [7:0] kccTripDegC(input logic [1:0] code);
    case (code)
      2'h0: kccTripDegC = 8'h8e;
      2'h1: kccTripDegC = 8'h7f;
      2'h2: kccTripDegC = 8'h70;
      default: kccTripDegC = 8'h61;
    endcase
  endfunction : kccTripDegC
endpackage : kcc_pkg

// >>> include/kcc_link_if.sv
// serial link between the host controller and the device
`timescale 1ns/1ps
interface kcc_link_if;
  logic sclk;
  logic csN;
  logic mosi;
  logic miso;
  modport device (input sclk, input csN, input mosi, output miso);
  modport host (output sclk, output csN, output mosi, input miso);
endinterface : kcc_link_if

// >>> rtl/kcc_host.sv
// host end: frames register writes onto the serial link
`timescale 1ns/1ps
module kcc_host #(
  parameter int SCLK_HALF = kcc_pkg::KCC_SCLK_HALF,
  parameter int CS_TAIL = kcc_pkg::KCC_CS_TAIL,
  parameter int FRAME_GAP = kcc_pkg::KCC_FRAME_GAP
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [1:0] regAddr,
  input wire logic [23:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [23:0] regRdata,
  kcc_link_if.host link
);
  import kcc_pkg::*;

  kcc_hstate_t state_r;
  logic [7:0] cnt_r;
  logic [4:0] bitCnt_r;
  logic [23:0] txSh_r;
  logic [23:0] rxSh_r;
  logic [23:0] rxLast_r;
  logic sclk_r;
  logic csN_r;
  logic mosi_r;
  logic misoSync1_r;
  logic misoSync2_r;

  always_ff @(posedge mclk) begin
    if (rst) begin
      misoSync1_r <= 1'b0;
      misoSync2_r <= 1'b0;
    end else begin
      misoSync1_r <= link.miso;
      misoSync2_r <= misoSync1_r;
    end
  end

  // software writes only the frame word; reserved codes are its to avoid
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_r <= HST_IDLE;
      cnt_r <= 8'h00;
      bitCnt_r <= 5'h00;
      txSh_r <= 24'h000000;
      rxSh_r <= 24'h000000;
      rxLast_r <= 24'h000000;
      sclk_r <= 1'b0;
      csN_r <= 1'b1;
      mosi_r <= 1'b0;
    end else begin
      case (state_r)
        HST_IDLE: begin
          if (regWr && regAddr == KCC_HREG_TX) begin
            txSh_r <= regWdata; // RULE14
            mosi_r <= regWdata[KCC_RD_BIT];
            csN_r <= 1'b0;
            cnt_r <= 8'h00;
            bitCnt_r <= 5'h00;
            state_r <= HST_SHIFT;
          end
        end
        HST_SHIFT: begin
          if (cnt_r == 8'(SCLK_HALF - 1)) begin
            cnt_r <= 8'h00;
            sclk_r <= ~sclk_r;
            if (sclk_r) begin
              rxSh_r <= {rxSh_r[22:0], misoSync2_r};
              if (bitCnt_r == KCC_LAST_BIT) begin
                state_r <= HST_TAIL;
              end else begin
                bitCnt_r <= bitCnt_r + 5'h01;
                mosi_r <= txSh_r[22];
                txSh_r <= {txSh_r[22:0], 1'b0};
              end
            end
          end else begin
            cnt_r <= cnt_r + 8'h01;
          end
        end
        // tail gives the device time to see the frame before select rises
        HST_TAIL: begin
          if (cnt_r == 8'(CS_TAIL - 1)) begin
            cnt_r <= 8'h00;
            csN_r <= 1'b1;
            rxLast_r <= rxSh_r;
            state_r <= HST_GAP;
          end else begin
            cnt_r <= cnt_r + 8'h01;
          end
        end
        HST_GAP: begin
          if (cnt_r == 8'(FRAME_GAP - 1)) begin
            cnt_r <= 8'h00;
            state_r <= HST_IDLE;
          end else begin
            cnt_r <= cnt_r + 8'h01;
          end
        end
        default: state_r <= HST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      regRdata <= 24'h000000;
    end else if (regRd) begin
      case (regAddr)
        KCC_HREG_STATUS: regRdata <= {23'h000000, state_r != HST_IDLE};
        KCC_HREG_RX: regRdata <= rxLast_r;
        default: regRdata <= 24'h000000;
      endcase
    end
  end

  assign link.sclk = sclk_r;
  assign link.csN = csN_r;
  assign link.mosi = mosi_r;
endmodule : kcc_host

// >>> verif/kcc_link_props.sv
// serial link protocol checker for the key command block
`timescale 1ns/1ps
module kcc_link_props (
  input wire logic mclk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic csN,
  input wire logic mosi,
  input wire logic miso
);
  logic [4:0] riseCnt_r;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // rises of the link clock within the open frame
  always_ff @(posedge mclk) begin
    if (rst || csN) begin
      riseCnt_r <= 5'h00;
    end else if ($rose(sclk)) begin
      riseCnt_r <= riseCnt_r + 5'h01;
    end
  end
  a_sclk_idle_low: assert property (csN |-> !sclk)
    else $error("link clock active outside a frame");
  a_frame_bits: assert property ($rose(csN) |-> riseCnt_r == 5'h18)
    else $error("frame closed without 24 link clock rises");
  a_sclk_high_len: assert property ($rose(sclk) |-> sclk[*3] ##1 !sclk)
    else $error("link clock high phase wrong length");
  a_sclk_low_len: assert property ($fell(sclk) && riseCnt_r != 5'h18 |-> !sclk[*3] ##1 sclk)
    else $error("link clock low phase wrong length");
  a_mosi_steady: assert property (sclk && $past(sclk) |-> $stable(mosi))
    else $error("host data moved while link clock high");
  a_tail_hold: assert property ($fell(sclk) && riseCnt_r == 5'h18 |-> !csN[*4])
    else $error("frame select released too early");
  a_gap_hold: assert property ($rose(csN) |-> csN[*8])
    else $error("next frame opened without a gap");
  a_start_bound: assert property ($fell(csN) |-> !sclk ##[1:8] sclk)
    else $error("first link clock rise late");
  a_miso_on_rise: assert property (!csN && !$past(csN) && $changed(miso) |-> sclk)
    else $error("device data moved while link clock low");
endmodule : kcc_link_props

// >>> verif/key_command_and_misc_config_tb.sv
// self-checking bench joining host and device ends over the link
`timescale 1ns/1ps
module key_command_and_misc_config_tb;
  import kcc_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic alarmPin = 1'b0;
  logic [1:0] regAddr = 2'h0;
  logic [23:0] regWdata = 24'h000000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [23:0] regRdata;
  logic cfgLocked, lockCrcStart, swResetStart, adcStart, wdogReset, crcRecalc, calRefresh, clockOutputPin;
  logic [1:0] tempTripSel, clkOutSel;
  logic [7:0] tempTripDegC;
  logic [2:0] clkOutRate;
  logic [5:0] pulses;
  logic [5:0] pulseQ[$];
  int fail_count = 0;
  int tests_run = 0;
  int seed = 88;
  int khz[8] = '{416, 435, 454, 476, 500, 526, 555, 588};
  logic [7:0] degC[4] = '{8'h8e, 8'h7f, 8'h70, 8'h61};
  logic [15:0] keys[18] = '{16'h1adc, 16'h5cea, 16'hfcba, 16'hfcba, 16'h1234, 16'h15fa, 16'h0001, 16'h0d06,
    16'h0002, 16'h0d06, 16'h1234, 16'h0002, 16'h4765, 16'h896d, 16'h1adc, 16'h57ab, 16'h896d, 16'h57ab};
  logic [5:0] kexp[18] = '{6'h08, 6'h02, 6'h01, 6'h00, 6'h00, 6'h00, 6'h10, 6'h00, 6'h04, 6'h00, 6'h00,
    6'h00, 6'h20, 6'h00, 6'h08, 6'h00, 6'h00, 6'h00};
  logic [17:0] lkexp = 18'h1f000;
  kcc_link_if link();
  always #5 mclk = ~mclk;
  kcc_host u_kcc_host (.mclk(mclk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .link(link));
  kcc_device u_kcc_device (.mclk(mclk), .rst(rst), .alarmPin(alarmPin), .link(link), .cfgLocked(cfgLocked),
    .lockCrcStart(lockCrcStart), .swResetStart(swResetStart), .adcStart(adcStart), .wdogReset(wdogReset),
    .crcRecalc(crcRecalc), .calRefresh(calRefresh), .tempTripSel(tempTripSel), .tempTripDegC(tempTripDegC),
    .clkOutSel(clkOutSel), .clkOutRate(clkOutRate), .clockOutputPin(clockOutputPin));
  kcc_link_props u_kcc_link_props (.mclk(mclk), .rst(rst), .sclk(link.sclk), .csN(link.csN),
    .mosi(link.mosi), .miso(link.miso));

  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  // every pulse seen takes the oldest note; an empty queue means an unexpected pulse
  assign pulses = {lockCrcStart, swResetStart, adcStart, wdogReset, crcRecalc, calRefresh};
  always @(posedge mclk) begin
    if (!rst && pulses !== 6'h00) begin
      check("pulse", 24'(pulses), pulseQ.size() > 0 ? 24'(pulseQ.pop_front()) : 24'h0);
    end
  end

  task automatic busWr(input logic [1:0] a, input logic [23:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask : busWr

  task automatic busRd(input logic [1:0] a, output logic [23:0] d);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1;
    d = regRdata;
  endtask : busRd

  // one link frame, then poll until the host is idle again
  task automatic frame(input logic [23:0] w);
    logic [23:0] s;
    int n;
    s = 24'h000001;
    n = 0;
    busWr(KCC_HREG_TX, w);
    while (s[0] !== 1'b0 && n < 300) begin
      busRd(KCC_HREG_STATUS, s);
      n++;
    end
    if (n >= 300) fail_count++;
  endtask : frame

  task automatic key(input logic [15:0] k, input logic [5:0] e);
    if (e != 6'h00) pulseQ.push_back(e);
    frame({3'b000, KCC_ADDR_KEY, k});
  endtask : key

  // readback comes out during the frame after the request
  task automatic readBack(input logic [4:0] a, input logic [23:0] exp);
    logic [23:0] d;
    frame({3'b100, a, 16'h0000});
    frame(24'h000000);
    busRd(KCC_HREG_RX, d);
    check("readback", d, exp);
  endtask : readBack

  task automatic resetVals();
    check("locked", 24'(cfgLocked), 24'h0);
    check("trip", 24'(tempTripDegC), 24'h8e);
    check("cksel", 24'(clkOutSel), 24'h0);
    check("rate", 24'(clkOutRate), 24'h4);
    check("pin", 24'(clockOutputPin), 24'h0);
  endtask : resetVals

  task automatic halfLen(output int n);
    logic p;
    int k;
    k = 0;
    @(posedge mclk);
    p = clockOutputPin;
    while (clockOutputPin === p && k < 300) begin
      @(posedge mclk);
      k++;
    end
    p = clockOutputPin;
    n = 0;
    while (clockOutputPin === p && n < 300) begin
      @(posedge mclk);
      n++;
    end
  endtask : halfLen

  initial begin
    #400000;
    fail_count++;
    summarize();
  end

  initial begin
    logic [15:0] cw;
    logic [2:0] rate;
    int n;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    resetVals();
    for (int i = 0; i < 18; i++) begin
      key(keys[i], kexp[i]);
      check("lock", 24'(cfgLocked), 24'(lkexp[i]));
    end
    check("pending", 24'(pulseQ.size()), 24'h0);
    $display("test keys done");
    key(16'h4765, 6'h20);
    frame({3'b000, KCC_ADDR_CFG1, 16'h3204});
    check("locked trip", 24'(tempTripSel), 24'h0);
    key(16'h896d, 6'h00);
    key(16'h57ab, 6'h00);
    $display("test lock done");
    for (int i = 0; i < 4; i++) begin
      rate = 3'($random(seed));
      @(posedge mclk);
      alarmPin <= 1'($random(seed));
      cw = {2'b00, 2'(i), 1'b0, 1'(i), rate, 7'h04};
      frame({3'b000, KCC_ADDR_CFG1, cw});
      check("trip", 24'(tempTripSel), 24'(i));
      check("degc", 24'(tempTripDegC), 24'(degC[i]));
      check("cksel", 24'(clkOutSel), 24'(i % 2));
      check("rate", 24'(clkOutRate), 24'(rate));
      readBack(KCC_ADDR_CFG1, {2'b00, ~alarmPin, KCC_ADDR_CFG1, cw});
      if (i % 2 == 1) begin
        halfLen(n);
        check("half", 24'(n), 24'(100000 / (2 * khz[rate])));
      end else begin
        check("pin", 24'(clockOutputPin), 24'h0);
      end
    end
    $display("test config done");
    key(16'h1adc, 6'h08);
    readBack(KCC_ADDR_KEY, {2'b00, ~alarmPin, KCC_ADDR_KEY, 16'h0000});
    @(posedge mclk);
    rst <= 1'b1;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    resetVals();
    key(16'hfcba, 6'h01);
    check("pending", 24'(pulseQ.size()), 24'h0);
    $display("test reset done");
    summarize();
  end
endmodule : key_command_and_misc_config_tb
